// *** design/tcc_chan.v ***
`timescale 1ns/1ps
`include "tcc_defs.vh"
module tcc_chan (
    clock,
    rst_n,
    enable,
    buffered,
    ctrl,
    pin_sync,
    pin_prev,
    capture_ok,
    compare_ok,
    counter,
    match_value,
    wrap,
    event_hit,
    pin_out,
    pin_oe
);
    input wire clock;
    input wire rst_n;
    input wire enable;
    input wire buffered;
    input wire [5:0] ctrl;
    input wire pin_sync;
    input wire pin_prev;
    input wire capture_ok;
    input wire compare_ok;
    input wire [15:0] counter;
    input wire [15:0] match_value;
    input wire wrap;
    output wire event_hit;
    output reg pin_out;
    output wire pin_oe;

    wire mode_a = ctrl[4];
    wire [1:0] el = ctrl[3:2];
    wire tov = ctrl[1];
    wire max_bit = ctrl[0];
    wire is_compare = enable && (buffered || mode_a) && el != `TCC_EL_OFF;
    wire is_capture = enable && !buffered && !mode_a && el != `TCC_EL_OFF;
    wire rise = pin_sync && !pin_prev;
    wire fall = !pin_sync && pin_prev;
    reg edge_hit;
    reg max_latched;
    reg next_pin;
    wire match = is_compare && compare_ok && counter == match_value;
    wire do_wrap = is_compare && tov && wrap;

    always @* begin
        case (el)
            `TCC_EL_RISE: edge_hit = rise;
            `TCC_EL_FALL: edge_hit = fall;
            `TCC_EL_BOTH: edge_hit = rise || fall;
            default: edge_hit = 1'b0;
        endcase
    end

    assign event_hit = (is_capture && capture_ok && edge_hit) || match;
    assign pin_oe = is_compare || is_capture ? is_compare : 1'b0;

    always @* begin
        next_pin = pin_out;
        if (!is_compare && !is_capture) begin
            next_pin = !mode_a;
        end else if (is_compare) begin
            if (do_wrap) begin
                next_pin = max_latched ? 1'b1 : !pin_out;
            end else if (max_latched && tov) begin
                next_pin = 1'b1;
            end else if (match) begin
                case (el)
                    `TCC_EL_RISE: next_pin = !pin_out;
                    `TCC_EL_FALL: next_pin = 1'b0;
                    `TCC_EL_BOTH: next_pin = 1'b1;
                    default: next_pin = pin_out;
                endcase
            end
        end
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            pin_out <= 1'b1;
            max_latched <= 1'b0;
        end else begin
            pin_out <= next_pin;
            if (wrap) begin
                max_latched <= max_bit && tov;
            end
        end
    end
endmodule

// *** design/tcc_top.v ***
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "tcc_defs.vh"
module tcc_top (
    clock,
    rst_n,
    addr,
    wdata,
    wr,
    rd,
    rdata,
    counter,
    wrap,
    counter_halt,
    debug_break,
    pin0_in,
    pin1_in,
    pin0_out,
    pin0_oe,
    pin1_out,
    pin1_oe,
    irq0,
    irq1
);
    input wire clock;
    input wire rst_n;
    input wire [2:0] addr;
    input wire [7:0] wdata;
    input wire wr;
    input wire rd;
    output reg [7:0] rdata;
    input wire [15:0] counter;
    input wire wrap;
    input wire counter_halt;
    input wire debug_break;
    input wire pin0_in;
    input wire pin1_in;
    output wire pin0_out;
    output wire pin0_oe;
    output wire pin1_out;
    output wire pin1_oe;
    output wire irq0;
    output wire irq1;

    reg [5:0] ctrl0;
    reg [5:0] ctrl1;
    reg flag0;
    reg flag1;
    reg armed0;
    reg armed1;
    reg [15:0] value0;
    reg [15:0] value1;
    reg [7:0] high_hold0;
    reg [7:0] high_hold1;
    reg cap_lock0;
    reg cap_lock1;
    reg cmp_lock0;
    reg cmp_lock1;
    reg buf_sel;
    reg ie0;
    reg ie1;
    reg [1:0] meta;
    reg [1:0] sync;
    reg [1:0] prev;
    wire hit0;
    wire hit1;
    wire o0;
    wire o1;
    wire e0;
    wire e1;

    wire buffered = ctrl0[5];
    wire ch1_en = !buffered;
    wire cap_ok = !counter_halt && !debug_break;
    wire capture0 = !buffered && !ctrl0[4];
    wire capture1 = !ctrl1[4];
    wire [15:0] buf_value = buf_sel ? value1 : value0;
    wire [15:0] match0 = buffered ? buf_value : value0;

    // Clear on 0 write only after an armed read; event in same cycle wins
    function next_flag;
        input flag;
        input armed;
        input hit;
        input clr;
        next_flag = hit ? 1'b1 : ((clr && armed && !wdata[`TCC_BIT_FLAG]) ? 1'b0 : flag);
    endfunction

    always @(posedge clock) begin
        if (!rst_n) begin
            meta <= 2'h0;
            sync <= 2'h0;
            prev <= 2'h0;
        end else begin
            meta <= {pin1_in, pin0_in};
            sync <= meta;
            prev <= sync;
        end
    end

    tcc_chan u_ch0 (
        .clock(clock),
        .rst_n(rst_n),
        .enable(1'b1),
        .buffered(buffered),
        .ctrl(ctrl0),
        .pin_sync(sync[0]),
        .pin_prev(prev[0]),
        .capture_ok(cap_ok && !cap_lock0),
        .compare_ok(!cmp_lock0),
        .counter(counter),
        .match_value(match0),
        .wrap(wrap),
        .event_hit(hit0),
        .pin_out(o0),
        .pin_oe(e0)
    );

    tcc_chan u_ch1 (
        .clock(clock),
        .rst_n(rst_n),
        .enable(ch1_en),
        .buffered(1'b0),
        .ctrl(ctrl1),
        .pin_sync(sync[1]),
        .pin_prev(prev[1]),
        .capture_ok(cap_ok && !cap_lock1),
        .compare_ok(!cmp_lock1),
        .counter(counter),
        .match_value(value1),
        .wrap(wrap),
        .event_hit(hit1),
        .pin_out(o1),
        .pin_oe(e1)
    );

    assign pin0_out = o0;
    assign pin0_oe = e0;
    assign pin1_out = o1;
    assign pin1_oe = e1 && ch1_en;
    assign irq0 = flag0 && ie0;
    assign irq1 = flag1 && ie1 && ch1_en;

    wire w_cs0 = wr && addr == `TCC_ADDR_CS0;
    wire w_cs1 = wr && addr == `TCC_ADDR_CS1 && ch1_en;
    wire [6:0] wctl = wdata[6:0];

    always @(posedge clock) begin
        if (!rst_n) begin
            ctrl0 <= 6'h0;
            ctrl1 <= 6'h0;
            flag0 <= 1'b0;
            flag1 <= 1'b0;
            armed0 <= 1'b0;
            armed1 <= 1'b0;
            cap_lock0 <= 1'b0;
            cap_lock1 <= 1'b0;
            cmp_lock0 <= 1'b0;
            cmp_lock1 <= 1'b0;
            buf_sel <= 1'b0;
            ie0 <= 1'b0;
            ie1 <= 1'b0;
            rdata <= 8'h00;
        end else begin
            flag0 <= next_flag(flag0, armed0, hit0, w_cs0);
            flag1 <= next_flag(flag1, armed1, hit1 && ch1_en, w_cs1);
            if (hit0 || w_cs0) begin
                armed0 <= 1'b0;
            end else if (rd && addr == `TCC_ADDR_CS0 && flag0) begin
                armed0 <= 1'b1;
            end
            if (hit1 || w_cs1) begin
                armed1 <= 1'b0;
            end else if (rd && addr == `TCC_ADDR_CS1 && flag1 && ch1_en) begin
                armed1 <= 1'b1;
            end
            if (w_cs0) begin
                ctrl0 <= wctl[5:0];
                ie0 <= wctl[6];
            end
            if (w_cs1) begin
                ctrl1 <= {1'b0, wctl[4:0]};
                ie1 <= wctl[6];
            end
            if (!buffered) begin
                buf_sel <= 1'b0;
            end else if (wrap) begin
                buf_sel <= !buf_sel;
            end
            // Value byte access locks
            if (rd && addr == `TCC_ADDR_VH0 && capture0) begin
                cap_lock0 <= 1'b1;
            end else if (rd && addr == `TCC_ADDR_VL0) begin
                cap_lock0 <= 1'b0;
            end
            if (rd && addr == `TCC_ADDR_VH1 && capture1) begin
                cap_lock1 <= 1'b1;
            end else if (rd && addr == `TCC_ADDR_VL1) begin
                cap_lock1 <= 1'b0;
            end
            if (wr && addr == `TCC_ADDR_VH0 && !capture0) begin
                cmp_lock0 <= 1'b1;
            end else if (wr && addr == `TCC_ADDR_VL0) begin
                cmp_lock0 <= 1'b0;
            end
            if (wr && addr == `TCC_ADDR_VH1 && !capture1) begin
                cmp_lock1 <= 1'b1;
            end else if (wr && addr == `TCC_ADDR_VL1) begin
                cmp_lock1 <= 1'b0;
            end
            rdata <= 8'h00;
            if (rd) begin
                case (addr)
                    `TCC_ADDR_CS0: rdata <= {flag0, ie0, ctrl0};
                    `TCC_ADDR_VH0: rdata <= value0[15:8];
                    `TCC_ADDR_VL0: rdata <= value0[7:0];
                    `TCC_ADDR_CS1: rdata <= ch1_en ? {flag1, ie1, ctrl1} : 8'h00;
                    `TCC_ADDR_VH1: rdata <= value1[15:8];
                    `TCC_ADDR_VL1: rdata <= value1[7:0];
                    default: rdata <= 8'h00;
                endcase
            end
        end
    end

    // Value registers carry no reset
    always @(posedge clock) begin
        if (hit0 && capture0) begin
            value0 <= counter;
        end else if (wr && addr == `TCC_ADDR_VH0) begin
            value0[15:8] <= wdata;
        end else if (wr && addr == `TCC_ADDR_VL0) begin
            value0[7:0] <= wdata;
        end
        if (hit1 && capture1 && ch1_en) begin
            value1 <= counter;
        end else if (wr && addr == `TCC_ADDR_VH1) begin
            value1[15:8] <= wdata;
        end else if (wr && addr == `TCC_ADDR_VL1) begin
            value1[7:0] <= wdata;
        end
    end
endmodule

// *** inc/tcc_defs.vh ***
// Function
// - Capture mode sets the event flag on the selected pin edge.
// - Compare mode sets the event flag when counter equals channel value.
// - Flag clears by read-while-set then write 0; a newer event blocks the clear.
// - Reset clears the flag; writing 1 leaves it unchanged.
// - Interrupt request forwarded only while the enable bit is 1; reset clears it.
// - Buffered select exists only in channel 0; reset clears it.
// - Buffered select disables channel 1 control and frees its pin.
// - With edge field nonzero and buffered select 0, mode bit A picks compare (1) or capture (0).
// - With edge field 00, mode bit A picks initial level: 1 low, 0 high.
// - Edge field 00 leaves the pin to the port; channel holds its preset.
// - Capture edge field: 01 rising, 10 falling, 11 either.
// - Compare edge field: 01 toggle, 10 clear, 11 set on match.
// - Toggle-on-wrap toggles a compare pin at each wrap; no effect in capture.
// - Wrap action wins over a coincident compare match when toggle-on-wrap is set.
// - Toggle-on-wrap with full-duty forces the PWM output to 100 percent.
// - Full-duty changes take effect from the next period after the write.
// - Value registers hold capture or compare value; not reset.
// - Capture mode: reading high byte blocks captures until low byte is read.
// - Compare mode: writing high byte blocks matches until low byte is written.
// - Wrap occurs at the modulo value; counting restarts from zero.
// - Counter halt inhibits input captures.
// - Debug break inhibits input captures.
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH
`define TCC_ADDR_CS0 3'h0
`define TCC_ADDR_VH0 3'h1
`define TCC_ADDR_VL0 3'h2
`define TCC_ADDR_CS1 3'h3
`define TCC_ADDR_VH1 3'h4
`define TCC_ADDR_VL1 3'h5
`define TCC_BIT_FLAG 7
`define TCC_BIT_IE 6
`define TCC_BIT_MSB 5
`define TCC_BIT_MSA 4
`define TCC_BIT_ELSB 3
`define TCC_BIT_ELSA 2
`define TCC_BIT_TOV 1
`define TCC_BIT_MAX 0
`define TCC_EL_OFF 2'h0
`define TCC_EL_RISE 2'h1
`define TCC_EL_FALL 2'h2
`define TCC_EL_BOTH 2'h3
`endif

// *** tb/tcc_pin_env.sv ***
`timescale 1ns/1ps
module tcc_pin_env (
    input wire logic ext0,
    input wire logic pin0_out,
    input wire logic pin0_oe,
    output wire logic pin0_in
);
    // Channel wins while driving, else outside source
    assign pin0_in = pin0_oe ? pin0_out : ext0;
endmodule

// *** tb/tcc_top_bench.sv ***
`timescale 1ns/1ps
module tcc_top_bench;
    logic clock, rst_n, wr, rd, wrap, counter_halt, debug_break, ext0;
    logic [2:0] addr;
    logic [7:0] wdata, c;
    logic [15:0] counter;
    wire [7:0] rdata;
    wire pin0_in, pin0_out, pin0_oe, pin1_out, pin1_oe, irq0, irq1;
    int err_total, num_checks, el;
    tcc_top DUT (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .counter(counter), .wrap(wrap), .counter_halt(counter_halt),
        .debug_break(debug_break), .pin0_in(pin0_in), .pin1_in(1'b0), .pin0_out(pin0_out),
        .pin0_oe(pin0_oe), .pin1_out(pin1_out), .pin1_oe(pin1_oe), .irq0(irq0), .irq1(irq1));
    tcc_pin_env ENV (.ext0(ext0), .pin0_out(pin0_out), .pin0_oe(pin0_oe), .pin0_in(pin0_in));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rreg(input logic [2:0] a, input logic [7:0] exp, input logic on);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        if (on) chk(rdata, exp);
    endtask
    task automatic step(input logic [15:0] v, input logic w);
        @(posedge clock);
        counter <= v;
        wrap <= w;
        @(posedge clock);
        counter <= 16'h0000;
        wrap <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic pin(input logic v);
        @(posedge clock);
        ext0 <= v;
        repeat (8) @(posedge clock);
        #1;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        results();
    end
    initial begin
        {rst_n, wr, rd, wrap, counter_halt, debug_break, ext0} = 7'h00;
        addr = 3'h0;
        wdata = 8'h00;
        counter = 16'h1234;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        rreg(3'h0, 8'h00, 1);
        wreg(3'h6, 8'hff);
        rreg(3'h6, 8'h00, 1);
        $display("reset test done");
        for (el = 1; el < 4; el++) begin
            c = {4'h4, el[1:0], 2'h0};
            wreg(3'h0, c);
            pin(1'b1);
            chk(irq0, el != 2);
            rreg(3'h0, c | {el != 2, 7'h0}, 1);
            wreg(3'h0, c);
            pin(1'b0);
            rreg(3'h0, c | {el != 1, 7'h0}, 1);
            wreg(3'h0, c);
        end
        rreg(3'h0, c, 1);
        rreg(3'h1, 8'h12, 1);
        rreg(3'h2, 8'h34, 1);
        pin(1'b1);
        wreg(3'h0, 8'h4c);
        rreg(3'h0, 8'hcc, 1);
        pin(1'b0);
        wreg(3'h0, 8'h4c);
        rreg(3'h0, 8'hcc, 1);
        wreg(3'h0, 8'h4c);
        wreg(3'h0, 8'hcc);
        rreg(3'h0, 8'h4c, 1);
        for (el = 0; el < 2; el++) begin
            @(posedge clock);
            {counter_halt, debug_break} <= el ? 2'h1 : 2'h2;
            pin(!ext0);
            rreg(3'h0, 8'h4c, 1);
        end
        @(posedge clock);
        {counter_halt, debug_break} <= 2'h0;
        $display("capture test done");
        @(posedge clock);
        counter_halt <= 1'b1;
        wreg(3'h0, 8'h10);
        @(posedge clock);
        #1;
        chk({pin0_oe, pin0_out}, 8'h00);
        wreg(3'h1, 8'h00);
        wreg(3'h2, 8'h10);
        @(posedge clock);
        counter_halt <= 1'b0;
        for (el = 3; el > 0; el--) begin
            c = {4'h5, el[1:0], 2'h0};
            wreg(3'h0, c);
            step(16'h0010, 1'b0);
            chk({pin0_oe, pin0_out}, {1'b1, el[0]});
            rreg(3'h0, c | 8'h80, 1);
            wreg(3'h0, c);
        end
        wreg(3'h1, 8'h00);
        step(16'h0010, 1'b0);
        rreg(3'h0, 8'h54, 1);
        wreg(3'h2, 8'h20);
        step(16'h0020, 1'b0);
        rreg(3'h0, 8'hd4, 1);
        wreg(3'h0, 8'h5a);
        step(16'h0020, 1'b1);
        chk(pin0_out, 1'b1);
        step(16'h0000, 1'b1);
        chk(pin0_out, 1'b0);
        wreg(3'h0, 8'h5b);
        step(16'h0000, 1'b1);
        step(16'h0020, 1'b0);
        chk(pin0_out, 1'b1);
        $display("compare test done");
        rreg(3'h0, 8'h00, 0);
        wreg(3'h0, 8'h00);
        wreg(3'h2, 8'h30);
        wreg(3'h4, 8'h00);
        wreg(3'h5, 8'h40);
        wreg(3'h0, 8'h28);
        wreg(3'h3, 8'h5c);
        rreg(3'h0, 8'h28, 1);
        rreg(3'h3, 8'h00, 1);
        chk({pin0_oe, pin1_oe}, 8'h02);
        step(16'h0040, 1'b0);
        rreg(3'h0, 8'h28, 1);
        step(16'h0030, 1'b0);
        rreg(3'h0, 8'ha8, 1);
        wreg(3'h0, 8'h28);
        step(16'h0000, 1'b1);
        step(16'h0030, 1'b0);
        rreg(3'h0, 8'h28, 1);
        step(16'h0040, 1'b0);
        rreg(3'h0, 8'ha8, 1);
        $display("buffered test done");
        results();
    end
endmodule

// *** tb/tcc_top_properties.sv ***
`timescale 1ns/1ps
module tcc_top_props (
    input wire clock,
    input wire rst_n,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    input wire pin0_out,
    input wire pin0_oe,
    input wire pin1_oe,
    input wire irq0,
    input wire irq1
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    reset_state_a:
        assert property ($rose(rst_n) |-> rdata == 8'h00 && !irq0 && !irq1 && !pin0_oe)
        else $error("state not cleared by reset");
    irq0_level_a:
        assert property (rd && addr == 3'h0 |=> (rdata[7] && rdata[6]) == $past(irq0))
        else $error("irq0 differs from flag and enable");
    irq1_level_a:
        assert property (rd && addr == 3'h3 |=> (rdata[7] && rdata[6]) == $past(irq1))
        else $error("irq1 differs from flag and enable");
    buffered_irq_a:
        assert property (rd && addr == 3'h0 |=> !(rdata[5] && $past(irq1)))
        else $error("irq1 high in buffered mode");
    capture_oe_a:
        assert property (wr && addr == 3'h0 && wdata[5:4] == 2'h0 && wdata[3:2] != 2'h0
            |=> !pin0_oe)
        else $error("capture channel drives pin");
    compare_oe_a:
        assert property (wr && addr == 3'h0 && wdata[4] && wdata[3:2] != 2'h0 |=> pin0_oe)
        else $error("compare channel not driving pin");
    preset_level_a:
        assert property (wr && addr == 3'h0 && !wdata[5] && wdata[3:2] == 2'h0
            |=> ##1 !pin0_oe && pin0_out == !$past(wdata[4], 2))
        else $error("preset level wrong");
    buffered_pin1_a:
        assert property (wr && addr == 3'h0 && wdata[5] |=> !pin1_oe)
        else $error("pin1 driven in buffered mode");
endmodule
bind tcc_top tcc_top_props CHK (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pin0_out(pin0_out), .pin0_oe(pin0_oe),
    .pin1_oe(pin1_oe), .irq0(irq0), .irq1(irq1));
